// [src/emp_cfg.svh]
// emp_cfg.svh: frame layout constants and timing for the extended management port.
// assumes inclusion by bare name from the package and both ends.
`ifndef EMP_CFG_SVH
`define EMP_CFG_SVH
`define EMP_PREAMBLE_LEN 32
`define EMP_SOF 2'h1
`define EMP_OP_READ 2'h2
`define EMP_OP_WRITE 2'h1
`define EMP_SEL_MATCH 2'h3
`define EMP_TA_WRITE 2'h2
`define EMP_HDR_BITS 14
`define EMP_DATA_BITS 16
`define EMP_REG_COUNT 256
`define EMP_STD_PHY_LAST 5'h05
`define EMP_CUS_PHY_A 5'h1D
`define EMP_CUS_PHY_B 5'h1F
`define EMP_CLK_MHZ 250
`define EMP_MDC_MAX_MHZ 10
// divider half period in ref_clk cycles; least mdc period is 1000/10 ns
`define EMP_MDC_HALF ((`EMP_CLK_MHZ + 2 * `EMP_MDC_MAX_MHZ - 1) / (2 * `EMP_MDC_MAX_MHZ))
`endif

// [src/emp_pkg.sv]
// emp_pkg: types shared by both ends of the extended management port.
// assumes emp_cfg.svh is on the include path.
package emp_pkg;
    `include "emp_cfg.svh"
    typedef logic [7:0] emp_addr_t;
    typedef logic [7:0] emp_byte_t;
    typedef enum logic [6:0] {
        EMP_HUNT = 7'h01,
        EMP_SOF_S = 7'h02,
        EMP_HDR = 7'h04,
        EMP_TA = 7'h08,
        EMP_RDATA = 7'h10,
        EMP_WDATA = 7'h20,
        EMP_SKIP = 7'h40
    } emp_state_t;
endpackage : emp_pkg

// [src/emp_if.sv]
// emp_if: two-wire management link between controller and device.
// resolves the shared data wire here from the two enables, controller first.
`timescale 1ns/10ps
interface emp_if;
    logic mdc;
    logic mdio_ctl_o;
    logic mdio_ctl_oe_n;
    logic mdio_dev_o;
    logic mdio_dev_oe_n;
    logic mdio_i;
    // pulled high when nobody drives
    assign mdio_i = !mdio_ctl_oe_n ? mdio_ctl_o : (!mdio_dev_oe_n ? mdio_dev_o : 1'b1);
    modport device (input mdc, input mdio_i, output mdio_dev_o, output mdio_dev_oe_n);
    modport controller (output mdc, input mdio_i, output mdio_ctl_o, output mdio_ctl_oe_n);
endinterface : emp_if

// [src/emp_device.sv]
// emp_device: device end; decodes frames and holds the 256 eight-bit registers.
// assumes mdc is at most 10 MHz so each mdc phase spans several ref_clk cycles.
// Operation
// R1: frame needs 32 ones then 01
// R2: opcode 10 with select 11 reads
// R3: opcode 01 with select 11 writes
// R4: address from select 4,3,0 and register field
// R5: controller releases, device drives 0 in turnaround
// R6: controller sends 10 turnaround on writes
// R7: read returns zero upper byte, register lower
// R8: write keeps only low byte
// R9: all 256 addresses reachable
// R10: phy registers 0-5,29,31 reachable indirectly
// R11: mdc no faster than 10 MHz
// R12: sample on rise, change after rise; both ends here change their outputs after the fall
// R13: bad frame releases line, hunts preamble
`timescale 1ns/10ps
`include "emp_cfg.svh"
module emp_device
    import emp_pkg::*;
#(
    parameter int REG_COUNT = `EMP_REG_COUNT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    emp_if.device link,
    // indirect phy management path, answered combinationally by the phy block
    output logic [4:0] phy_port,
    output logic [4:0] phy_reg,
    output logic phy_rd,
    output logic phy_wr,
    output logic [15:0] phy_wdata,
    input wire logic [15:0] phy_rdata,
    output logic [7:0] cfg_addr,
    output logic cfg_wr
);
    initial begin
        if (REG_COUNT != `EMP_REG_COUNT) $error("emp_device: REG_COUNT must be 256");
    end
    logic mdc_s1_reg, mdc_s2_reg, mdc_s3_reg, io_s1_reg, io_s2_reg;
    emp_state_t state_reg;
    logic [5:0] cnt_reg;
    logic [13:0] hdr_reg;
    logic [15:0] shift_reg;
    logic phy_sel_reg;
    logic oe_n_reg, o_reg;
    logic [7:0] regs [REG_COUNT];
    logic rise, fall;
    logic [1:0] op;
    logic [4:0] dsel, rsel;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_s1_reg <= 1'b0;
            mdc_s2_reg <= 1'b0;
            mdc_s3_reg <= 1'b0;
            io_s1_reg <= 1'b1;
            io_s2_reg <= 1'b1;
        end else begin
            mdc_s1_reg <= link.mdc;
            mdc_s2_reg <= mdc_s1_reg;
            mdc_s3_reg <= mdc_s2_reg;
            io_s1_reg <= link.mdio_i;
            io_s2_reg <= io_s1_reg;
        end
    end
    assign rise = mdc_s2_reg && !mdc_s3_reg; // R12
    assign fall = !mdc_s2_reg && mdc_s3_reg;
    assign op = hdr_reg[11:10];
    assign dsel = hdr_reg[9:5];
    assign rsel = hdr_reg[4:0];

    function automatic emp_addr_t form_addr(input logic [4:0] d, input logic [4:0] r);
        form_addr = {d[4:3], d[0], r}; // R4 R9
    endfunction : form_addr

    // the phy path is used when the select field does not match 11 and the register is one listed here
    function automatic logic phy_reg_ok(input logic [4:0] r);
        phy_reg_ok = (r <= `EMP_STD_PHY_LAST) || (r == `EMP_CUS_PHY_A)
            || (r == `EMP_CUS_PHY_B); // R10
    endfunction : phy_reg_ok

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= EMP_HUNT;
            cnt_reg <= 6'h00;
            hdr_reg <= 14'h0000;
            phy_sel_reg <= 1'b0;
        end else if (rise) begin
            unique case (state_reg)
                EMP_HUNT: begin
                    if (!io_s2_reg) begin
                        cnt_reg <= 6'h00;
                    end else if (cnt_reg < 6'(`EMP_PREAMBLE_LEN)) begin
                        cnt_reg <= cnt_reg + 6'h01;
                    end
                    if (io_s2_reg && cnt_reg >= 6'(`EMP_PREAMBLE_LEN - 1)) begin
                        state_reg <= EMP_SOF_S; // R1
                    end
                end
                EMP_SOF_S: begin
                    // extra ones extend the preamble; a zero is the first start bit
                    if (!io_s2_reg) begin
                        state_reg <= EMP_HDR;
                        cnt_reg <= 6'h00;
                        hdr_reg <= 14'h0000;
                    end
                end
                EMP_HDR: begin
                    hdr_reg <= {hdr_reg[12:0], io_s2_reg};
                    cnt_reg <= cnt_reg + 6'h01;
                    if (cnt_reg == 6'(`EMP_HDR_BITS - 2)) begin
                        state_reg <= EMP_TA;
                        cnt_reg <= 6'h00;
                    end
                end
                EMP_TA: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (hdr_reg[13:12] != `EMP_SOF) begin
                        state_reg <= EMP_SKIP; // R13
                        cnt_reg <= 6'h00;
                    end else if (cnt_reg == 6'h00) begin
                        phy_sel_reg <= dsel[2:1] != `EMP_SEL_MATCH && phy_reg_ok(rsel);
                        if (op != `EMP_OP_READ && op != `EMP_OP_WRITE) begin
                            // skip must count all 17 remaining rises, or a trailing one
                            // would be taken as preamble
                            state_reg <= EMP_SKIP; // R13
                            cnt_reg <= 6'h00;
                        end
                    end else begin
                        cnt_reg <= 6'h00;
                        state_reg <= (op == `EMP_OP_READ) ? EMP_RDATA : EMP_WDATA;
                    end
                end
                EMP_RDATA, EMP_WDATA: begin
                    cnt_reg <= cnt_reg + 6'h01;
                    if (cnt_reg == 6'(`EMP_DATA_BITS - 1)) begin
                        state_reg <= EMP_HUNT;
                        cnt_reg <= 6'h00;
                    end
                end
                EMP_SKIP: begin
                    // wait out the rest of the frame before hunting again
                    cnt_reg <= cnt_reg + 6'h01;
                    if (cnt_reg == 6'(`EMP_DATA_BITS)) begin
                        state_reg <= EMP_HUNT;
                        cnt_reg <= 6'h00;
                    end
                end
                default: state_reg <= EMP_HUNT;
            endcase
        end
    end

    // start bit 0 is consumed in EMP_SOF_S, so hdr_reg[12:0] holds the 1 plus 12 bits;
    // the header fills as {start_lo, op, dsel, rsel} and sof check compares {0,start_lo}
    logic sel_cfg;
    assign sel_cfg = dsel[2:1] == `EMP_SEL_MATCH;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 16'h0000;
        end else if (rise && state_reg == EMP_TA && cnt_reg == 6'h01) begin
            shift_reg <= sel_cfg ? {8'h00, regs[form_addr(dsel, rsel)]} : phy_rdata; // R7
        end else if (rise && state_reg == EMP_WDATA) begin
            shift_reg <= {shift_reg[14:0], io_s2_reg};
        end else if (rise && state_reg == EMP_RDATA) begin
            // shift once the controller has taken the bit, so the next fall shows the next one
            shift_reg <= {shift_reg[14:0], 1'b0};
        end
    end

    // drive after the falling edge so bits are stable at the next controller sample
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_n_reg <= 1'b1;
            o_reg <= 1'b1;
        end else if (fall) begin
            if (state_reg == EMP_TA && cnt_reg == 6'h01 && op == `EMP_OP_READ
                    && (sel_cfg || phy_sel_reg)) begin
                oe_n_reg <= 1'b0; // R5 R12
                o_reg <= 1'b0;
            end else if (state_reg == EMP_RDATA && (sel_cfg || phy_sel_reg)) begin
                oe_n_reg <= 1'b0;
                o_reg <= shift_reg[15]; // R7
            end else begin
                oe_n_reg <= 1'b1; // R13
                o_reg <= 1'b1;
            end
        end
    end
    assign link.mdio_dev_o = o_reg;
    assign link.mdio_dev_oe_n = oe_n_reg;

    logic wr_done;
    assign wr_done = rise && state_reg == EMP_WDATA && cnt_reg == 6'(`EMP_DATA_BITS - 1);

    always_ff @(posedge ref_clk) begin
        if (wr_done && sel_cfg) begin
            regs[form_addr(dsel, rsel)] <= {shift_reg[6:0], io_s2_reg}; // R3 R8
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_addr <= 8'h00;
            cfg_wr <= 1'b0;
            phy_port <= 5'h00;
            phy_reg <= 5'h00;
            phy_rd <= 1'b0;
            phy_wr <= 1'b0;
            phy_wdata <= 16'h0000;
        end else begin
            cfg_wr <= wr_done && sel_cfg;
            cfg_addr <= form_addr(dsel, rsel);
            phy_port <= dsel;
            phy_reg <= rsel;
            phy_rd <= rise && state_reg == EMP_TA && cnt_reg == 6'h00 && op == `EMP_OP_READ
                && hdr_reg[13:12] == `EMP_SOF && !sel_cfg && phy_reg_ok(rsel); // R2 R10
            phy_wr <= wr_done && phy_sel_reg; // R10
            // held from the last write so it stands while the phy block takes it
            if (wr_done) begin
                phy_wdata <= {shift_reg[14:0], io_s2_reg};
            end
        end
    end
endmodule : emp_device

// [src/emp_controller.sv]
// emp_controller: controller end; makes mdc by division and runs one frame per request.
// assumes the device answers in turnaround and data phases of read frames.
`timescale 1ns/10ps
`include "emp_cfg.svh"
module emp_controller
    import emp_pkg::*;
#(
    parameter int HALF = `EMP_MDC_HALF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    emp_if.controller link,
    input wire logic req,
    input wire logic req_write,
    input wire logic [4:0] req_dsel,
    input wire logic [4:0] req_rsel,
    input wire logic [15:0] req_wdata,
    output logic busy,
    output logic done,
    output logic [15:0] rdata
);
    initial begin
        if (HALF < `EMP_MDC_HALF) $error("emp_controller: mdc above 10 MHz"); // R11
        if (HALF > 256) $error("emp_controller: HALF does not fit the divider");
    end
    localparam int FRAME = `EMP_PREAMBLE_LEN + 32;
    logic [7:0] div_reg;
    logic mdc_reg, o_reg, oe_n_reg, io_s1_reg, io_s2_reg;
    logic [6:0] bit_reg;
    logic [63:0] frame_reg;
    logic rd_reg;
    logic [15:0] cap_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_s1_reg <= 1'b1;
            io_s2_reg <= 1'b1;
        end else begin
            io_s1_reg <= link.mdio_i;
            io_s2_reg <= io_s1_reg;
        end
    end

    logic tick;
    assign tick = busy && div_reg == 8'(HALF - 1);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 8'h00;
            mdc_reg <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            bit_reg <= 7'h00;
            frame_reg <= 64'h0;
            rd_reg <= 1'b0;
            o_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            cap_reg <= 16'h0000;
            rdata <= 16'h0000;
        end else begin
            done <= 1'b0;
            if (!busy) begin
                if (req) begin
                    busy <= 1'b1;
                    div_reg <= 8'h00;
                    bit_reg <= 7'h00;
                    rd_reg <= !req_write;
                    frame_reg <= {32'hFFFFFFFF, `EMP_SOF, // R1
                        req_write ? `EMP_OP_WRITE : `EMP_OP_READ, req_dsel, req_rsel,
                        req_write ? `EMP_TA_WRITE : 2'h3, req_wdata}; // R6 R8
                    o_reg <= 1'b1;
                    // the pull-up gives the first preamble one; driving only from the
                    // first fall leaves the device time to let go after a read
                    oe_n_reg <= 1'b1;
                end
            end else begin
                div_reg <= tick ? 8'h00 : div_reg + 8'h01;
                if (tick) begin
                    mdc_reg <= !mdc_reg;
                    if (mdc_reg) begin
                        // falling edge: present next bit
                        o_reg <= frame_reg[63];
                        oe_n_reg <= rd_reg && bit_reg >= 7'(FRAME - 18); // R5
                        // end on the fall after the last rise: the device sees all
                        // rises and mdc rests low
                        if (bit_reg == 7'(FRAME)) begin
                            busy <= 1'b0;
                            done <= 1'b1;
                            oe_n_reg <= 1'b1;
                            if (rd_reg) begin
                                rdata <= cap_reg;
                            end
                        end
                    end else begin
                        if (rd_reg && bit_reg >= 7'(FRAME - 16)) begin
                            cap_reg <= {cap_reg[14:0], io_s2_reg};
                        end
                        frame_reg <= {frame_reg[62:0], 1'b1};
                        bit_reg <= bit_reg + 7'h01;
                    end
                end
            end
        end
    end
    assign link.mdc = mdc_reg;
    assign link.mdio_ctl_o = o_reg;
    assign link.mdio_ctl_oe_n = oe_n_reg;
endmodule : emp_controller

// [testbench/emp_link_assertions.sv]
// emp_link_assertions: protocol checks on the joined management link.
// assumes the controller divides mdc to at least 25 ref_clk cycles a period.
`timescale 1ns/10ps
module emp_link_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic mdc,
    input wire logic mdio_ctl_o,
    input wire logic mdio_ctl_oe_n,
    input wire logic mdio_dev_o,
    input wire logic mdio_dev_oe_n,
    input wire logic mdio_i
);
    logic mdc_d_reg;
    logic [9:0] per_reg;
    logic [9:0] drv_reg;
    logic [5:0] ones_reg;
    logic [4:0] rem_reg;
    wire mdc_rise = mdc && !mdc_d_reg;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // period starts saturated so the first rise after reset never looks fast
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mdc_d_reg <= 1'h0;
            per_reg <= 10'h3FF;
        end else begin
            mdc_d_reg <= mdc;
            per_reg <= mdc_rise ? 10'h001 : per_reg + {9'h000, per_reg != 10'h3FF};
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            drv_reg <= 10'h000;
        end else begin
            drv_reg <= mdio_dev_oe_n ? 10'h000 : drv_reg + 10'h001;
        end
    end
    // rem counts frame bits left after the first start bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ones_reg <= 6'h00;
            rem_reg <= 5'h00;
        end else if (mdc_rise) begin
            ones_reg <= !mdio_i ? 6'h00 : ones_reg + {5'h00, ones_reg != 6'h3F};
            rem_reg <= (rem_reg != 5'h00) ? rem_reg - 5'h01 : (mdio_i ? 5'h00 : 5'h1F);
        end
    end
    sequence s_dev_hold;
        !mdio_dev_oe_n [*8];
    endsequence
    a_no_contention: assert property (!(!mdio_ctl_oe_n && !mdio_dev_oe_n))
        else $error("both ends drive the data line");
    a_ta_release: assert property ($fell(mdio_dev_oe_n) |-> $past(mdio_ctl_oe_n, 13))
        else $error("device drove before the controller let go");
    a_ta_zero: assert property ($fell(mdio_dev_oe_n) |-> !mdio_dev_o ##1 s_dev_hold)
        else $error("turnaround answer is not a held zero");
    a_read_length: assert property ($rose(mdio_dev_oe_n) |-> drv_reg inside {[10'h1A4:10'h1CC]})
        else $error("device drove a wrong number of bits");
    a_dev_rise_stable: assert property (mdc_rise |-> $stable(mdio_dev_o) && $stable(mdio_dev_oe_n))
        else $error("device output moved at an mdc rise");
    a_ctl_rise_stable: assert property (mdc_rise |-> $stable(mdio_ctl_o))
        else $error("controller output moved at an mdc rise");
    a_mdc_rate: assert property (mdc_rise |-> per_reg >= 10'h019)
        else $error("mdc period too short");
    a_preamble_len: assert property (mdc_rise && rem_reg == 5'h00 && !mdio_i |-> ones_reg >= 6'h20)
        else $error("frame started without a full preamble");
    a_start_one: assert property (mdc_rise && rem_reg == 5'h1F |-> mdio_i)
        else $error("second start bit is not one");
endmodule : emp_link_assertions

// [testbench/tb_smi_register_access_slave.sv]
// tb_smi_register_access_slave: both ends joined, plus a bench-driven fault link.
// assumes the package, interface and both ends are compiled first.
`timescale 1ns/10ps
module tb_smi_register_access_slave;
    import emp_pkg::*;
    logic ref_clk = 1'h0;
    logic rst_n = 1'h0;
    logic req = 1'h0;
    logic req_write = 1'h0;
    logic [4:0] req_dsel = 5'h00;
    logic [4:0] req_rsel = 5'h00;
    logic [15:0] req_wdata = 16'h0000;
    logic [15:0] phy_rdata = 16'h0000;
    logic busy, done, phy_rd, phy_wr, cfg_wr, cfg_wr_b;
    logic [15:0] rdata, phy_wdata;
    logic [4:0] phy_port, phy_reg;
    logic [7:0] cfg_addr, cfg_addr_b;
    logic [4:0] regs [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1D, 5'h1F};
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int n_cfg = 0, n_rd = 0, n_wr = 0, n_cfg_b = 0, n_drv_b = 0;
    emp_if link ();
    emp_if flt ();
    always #2 ref_clk = ~ref_clk;
    emp_controller emp_controller_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link.controller),
        .req(req), .req_write(req_write), .req_dsel(req_dsel), .req_rsel(req_rsel),
        .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata));
    emp_device emp_device_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link.device),
        .phy_port(phy_port), .phy_reg(phy_reg), .phy_rd(phy_rd), .phy_wr(phy_wr),
        .phy_wdata(phy_wdata), .phy_rdata(phy_rdata), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr));
    emp_device emp_device_fault_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(flt.device),
        .phy_port(), .phy_reg(), .phy_rd(), .phy_wr(), .phy_wdata(),
        .phy_rdata(16'h0000), .cfg_addr(cfg_addr_b), .cfg_wr(cfg_wr_b));
    emp_link_assertions emp_link_assertions_i (.ref_clk(ref_clk), .rst_n(rst_n), .mdc(link.mdc),
        .mdio_ctl_o(link.mdio_ctl_o), .mdio_ctl_oe_n(link.mdio_ctl_oe_n),
        .mdio_dev_o(link.mdio_dev_o), .mdio_dev_oe_n(link.mdio_dev_oe_n), .mdio_i(link.mdio_i));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [4:0] sel(input logic [7:0] a);
        return {a[7:6], 2'h3, a[5]};
    endfunction : sel
    task automatic close_out();
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic frame(input logic wr, input logic [4:0] ds, input logic [4:0] rs,
            input logic [15:0] wd);
        int n;
        n = 0;
        while (busy !== 1'h0) @(negedge ref_clk);
        req = 1'h1;
        req_write = wr;
        req_dsel = ds;
        req_rsel = rs;
        req_wdata = wd;
        @(negedge ref_clk);
        req = 1'h0;
        check("busy", {15'h0000, busy}, 16'h0001);
        while (done !== 1'h1 && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 3000) begin
            fail_count++;
            close_out();
        end
    endtask : frame
    // bench mdc stands still between frames
    task automatic bang(input logic [63:0] bits);
        flt.mdio_ctl_oe_n = 1'h0;
        for (int i = 63; i >= 0; i--) begin
            flt.mdio_ctl_o = bits[i];
            repeat (4) @(negedge ref_clk);
            flt.mdc = 1'h1;
            repeat (4) @(negedge ref_clk);
            flt.mdc = 1'h0;
        end
        flt.mdio_ctl_oe_n = 1'h1;
        repeat (8) @(negedge ref_clk);
    endtask : bang
    always @(posedge ref_clk) begin
        cycles++;
        if (cfg_wr === 1'h1) n_cfg++;
        if (phy_rd === 1'h1) n_rd++;
        if (phy_wr === 1'h1) n_wr++;
        if (cfg_wr_b === 1'h1) n_cfg_b++;
        if (flt.mdio_dev_oe_n === 1'h0) n_drv_b++;
        if (cycles == 45000) begin
            fail_count++;
            close_out();
        end
    end
    initial begin
        logic [15:0] r;
        logic [15:0] d;
        logic [7:0] a;
        logic [4:0] ds;
        int c;
        int c2;
        r = 16'h5D95;
        flt.mdc = 1'h0;
        flt.mdio_ctl_o = 1'h1;
        flt.mdio_ctl_oe_n = 1'h1;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'h1;
        // both address extremes first, then random ones, frames back to back
        for (int k = 0; k < 6; k++) begin
            r = lfsr(r);
            a = (k == 0) ? 8'h00 : ((k == 1) ? 8'hFF : r[7:0]);
            d = lfsr(r);
            c = n_cfg;
            frame(1'h1, sel(a), a[4:0], d);
            check("cfg writes", 16'(n_cfg - c), 16'h0001);
            check("cfg address", {8'h00, cfg_addr}, {8'h00, a});
            frame(1'h0, sel(a), a[4:0], ~d);
            check("cfg read", rdata, {8'h00, d[7:0]});
        end
        for (int k = 0; k < 8; k++) begin
            r = lfsr(r);
            ds = r[4:0] & 5'h1B;
            c = k[0] ? n_wr : n_rd;
            phy_rdata = lfsr(r);
            frame(k[0], ds, regs[k], r);
            check("phy strobes", 16'(k[0] ? n_wr - c : n_rd - c), 16'h0001);
            check("phy target", {6'h00, phy_port, phy_reg}, {6'h00, ds, regs[k]});
            check("phy data", k[0] ? phy_wdata : rdata, k[0] ? r : phy_rdata);
        end
        c = n_rd + n_cfg;
        frame(1'h0, 5'h00, 5'h10, 16'h0000);
        check("released read", rdata, 16'hFFFF);
        check("unselected strobes", 16'(n_rd + n_cfg - c), 16'h0000);
        // bad start, bad opcode, then a good write with turnaround 10
        for (int k = 0; k < 3; k++) begin
            c = n_cfg_b;
            c2 = n_drv_b;
            bang({32'hFFFF_FFFF, (k == 0) ? 2'h0 : 2'h1, (k == 1) ? 2'h3 : 2'h1,
                sel(8'h5A), 5'h1A, 2'h2, 16'hC35A});
            check("fault link writes", 16'(n_cfg_b - c), {15'h0000, k == 2});
            check("fault link drive", 16'(n_drv_b - c2), 16'h0000);
        end
        check("fault link address", {8'h00, cfg_addr_b}, 16'h005A);
        close_out();
    end
endmodule : tb_smi_register_access_slave
